// [pkg/fault_pkg.sv]
// Purpose: shared constants and carriers for the fault collection unit
// Assumes: core clock of 100 MHz, internal rc oscillator nominally 16 MHz
// Notes: long half-period counts are defaults of top-level parameters
package fault_pkg;

    // clocking
    localparam int CLK_MHZ = 100;
    localparam int IRC_MHZ = 16;
    // conveying a fault into the unit, in oscillator cycles
    localparam int CONVEY_IRC_CYCLES = 10;
    localparam int CONVEY_CLK_CYCLES = (CONVEY_IRC_CYCLES * CLK_MHZ) / IRC_MHZ;
    // immediate indication bound
    localparam int FAST_IND_US = 64;
    localparam int FAST_HALF_CYCLES = FAST_IND_US * CLK_MHZ;
    // slow toggle: 61 Hz, half-period bound of 8 ms
    localparam int SLOW_TOGGLE_HZ = 61;
    localparam int SLOW_HALF_MS = 8;
    localparam int SLOW_HALF_CYCLES = SLOW_HALF_MS * 1000 * CLK_MHZ;

    // widths and reset values
    localparam int NUM_SOURCES = 8;
    localparam int HOLD_W = 24;
    localparam int DIV_W = 24;
    localparam logic [NUM_SOURCES-1:0] SRC_RESET = 8'h00;

    typedef enum logic [1:0] {
        proto_dual_rail,
        proto_time_switch,
        proto_bistable,
        proto_test
    } proto_t;

    typedef enum {
        st_hiz,
        st_fault,
        st_hold,
        st_oper
    } state_t;

    // software configuration
    typedef struct packed {
        proto_t proto;
        logic fast_mode;
        logic oper_b_high;
        logic test_a;
        logic test_b;
        logic [HOLD_W-1:0] hold_cycles;
    } cfg_t;

    // two error pins, three signals each minus the unused input side
    typedef struct packed {
        logic a_o;
        logic a_oe;
        logic b_o;
        logic b_oe;
    } pins_t;

endpackage : fault_pkg

// [src/toggle_divider.sv]
// Purpose: fixed divider giving the error pin toggle phase
// Assumes: half-period counts are at least 2
// Notes: boundary pulses on the cycle the phase flips
`timescale 1ns/10ps
module toggle_divider #(
    parameter int DIV_W = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // half-period length in clock cycles
    input wire logic [DIV_W-1:0] half_cycles,
    // phase and boundary pulse
    output logic phase_r,
    output logic boundary_r
);

    logic [DIV_W-1:0] cnt_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_r <= '0;
            phase_r <= 1'b0;
            boundary_r <= 1'b0;
        end
        else if (cnt_r >= half_cycles - DIV_W'(1))
        begin
            cnt_r <= '0;
            phase_r <= ~phase_r;
            boundary_r <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + DIV_W'(1);
            boundary_r <= 1'b0;
        end
    end

endmodule : toggle_divider

// [src/fault_collection_unit.sv]
// Purpose: collects internal faults and signals them on two error pins
// Assumes: fault inputs come from logic on clk; config is static while operational
// Notes: pins stay high impedance after power-on until software acts or a fault or functional reset arrives
//
// Summary of operation
// - collect safety mechanism faults in hardware, enter safe state, signal externally
// - a fault reaches the unit within ten oscillator cycles
// - fast switching and bi-stable protocols show a fault within 64 us
// - slow switching may delay indication by one half-period, at most 8 ms
// - exactly two dedicated error output pins
// - protocol selectable: dual rail, time switching, bi-stable, test
// - after power-on pins are high impedance or show failure, never operational
// - readable error flag; software writes 1 for fault, 0 for operational
// - pins return to operational only on explicit software request
// - while operational at least one pin is driven high, except in the test protocol
// - bi-stable pins complementary; software picks which pin is high when operational
// - after software clears a failure, pins hold failure for configured time
// - recorded fault source survives a functional reset
`timescale 1ns/10ps
module fault_collection_unit
    import fault_pkg::*;
#(
    parameter int FAST_HALF = fault_pkg::FAST_HALF_CYCLES,
    parameter int SLOW_HALF = fault_pkg::SLOW_HALF_CYCLES
) (
    // clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic func_rst,
    // fault reports from safety mechanisms
    input wire logic [fault_pkg::NUM_SOURCES-1:0] fault_in,
    // software control
    input wire fault_pkg::cfg_t cfg,
    input wire logic flag_wr,
    input wire logic flag_wdata,
    input wire logic [fault_pkg::NUM_SOURCES-1:0] src_clr,
    // software status
    output logic err_flag_r,
    output logic [fault_pkg::NUM_SOURCES-1:0] fault_src_r,
    // error pins
    output fault_pkg::pins_t pins_r
);
    import fault_pkg::*;

    state_t state_r;
    logic [NUM_SOURCES-1:0] fault_q_r;
    logic [HOLD_W-1:0] hold_cnt_r;
    logic shown_fault_r;
    logic shown_hiz_r;
    logic phase;
    logic boundary;
    logic fault_any;
    logic immediate;
    logic [DIV_W-1:0] half_sel;
    pins_t pins_nxt;

    assign fault_any = |fault_q_r;
    assign immediate = cfg.fast_mode || (cfg.proto == proto_bistable) || (cfg.proto == proto_test);
    assign half_sel = cfg.fast_mode ? DIV_W'(FAST_HALF) : DIV_W'(SLOW_HALF);

    toggle_divider #(
        .DIV_W(DIV_W)
    ) u_div (
        .clk(clk),
        .rst(rst),
        .half_cycles(half_sel),
        .phase_r(phase),
        .boundary_r(boundary)
    );

    // one register stage keeps conveyance far inside its bound
    always_ff @(posedge clk)
    begin
        if (rst)
            fault_q_r <= '0;
        else
            fault_q_r <= fault_in;
    end

    // sticky source record; power-on reset or src_clr clears it, func_rst does not, a new fault beats a clear
    always_ff @(posedge clk)
    begin
        if (rst)
            fault_src_r <= SRC_RESET;
        else
            fault_src_r <= (fault_src_r & ~src_clr) | fault_q_r;
    end

    // unit state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r <= st_hiz;
            hold_cnt_r <= '0;
        end
        else if (fault_any || func_rst)
        begin
            state_r <= st_fault;
            hold_cnt_r <= '0;
        end
        else
        begin
            case (state_r)
                st_hiz, st_oper:
                begin
                    if (flag_wr && flag_wdata)
                        state_r <= st_fault;
                    else if (flag_wr && state_r == st_hiz)
                        state_r <= st_hold;
                    hold_cnt_r <= '0;
                end
                st_fault:
                begin
                    if (flag_wr && !flag_wdata)
                        state_r <= st_hold;
                    hold_cnt_r <= '0;
                end
                st_hold:
                begin
                    // failure pattern lingers so the supervisor cannot miss it
                    if (flag_wr && flag_wdata)
                        state_r <= st_fault;
                    else if (hold_cnt_r >= cfg.hold_cycles)
                        state_r <= st_oper;
                    hold_cnt_r <= hold_cnt_r + HOLD_W'(1);
                end
                default:
                    state_r <= st_fault;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            err_flag_r <= 1'b1;
        else
            err_flag_r <= (state_r != st_oper);
    end

    // what the pins show; slow switching only moves on a half-period edge
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            shown_fault_r <= 1'b1;
            shown_hiz_r <= 1'b1;
        end
        else if (immediate || boundary)
        begin
            shown_fault_r <= (state_r != st_oper);
            shown_hiz_r <= (state_r == st_hiz);
        end
    end

    always_comb
    begin
        pins_nxt = '0;
        case (cfg.proto)
            proto_dual_rail:
            begin
                pins_nxt.a_o = phase;
                pins_nxt.b_o = shown_fault_r ? phase : ~phase;
            end
            proto_time_switch:
            begin
                pins_nxt.a_o = shown_fault_r ? 1'b0 : phase;
                pins_nxt.b_o = ~shown_fault_r;
            end
            proto_bistable:
            begin
                pins_nxt.b_o = cfg.oper_b_high ^ shown_fault_r;
                pins_nxt.a_o = ~pins_nxt.b_o;
            end
            proto_test:
            begin
                pins_nxt.a_o = cfg.test_a;
                pins_nxt.b_o = cfg.test_b;
            end
            default:
            begin
                pins_nxt.a_o = 1'b0;
                pins_nxt.b_o = 1'b0;
            end
        endcase
        // high impedance reads as failure on the supervisor side
        pins_nxt.a_oe = ~shown_hiz_r;
        pins_nxt.b_oe = ~shown_hiz_r;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            pins_r <= '0;
        else
            pins_r <= pins_nxt;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_reset_hiz;
        $past(rst) |-> !pins_r.a_oe && !pins_r.b_oe && err_flag_r;
    endproperty
    a_reset_hiz: assert property (p_reset_hiz) else $error("pins driven after reset");

    property p_fault_flag;
        (|fault_in) && !func_rst |-> ##[1:3] err_flag_r;
    endproperty
    a_fault_flag: assert property (p_fault_flag) else $error("fault did not raise flag");

    property p_fault_convey;
        (|fault_in) |-> ##[1:2] (state_r == st_fault);
    endproperty
    a_fault_convey: assert property (p_fault_convey) else $error("fault not conveyed in time");

    property p_fast_show;
        (|fault_q_r) && immediate |-> ##[1:2] shown_fault_r;
    endproperty
    a_fast_show: assert property (p_fast_show) else $error("fast indication late");

    property p_slow_edge;
        !immediate && !$past(immediate) && $changed(shown_fault_r) |-> $past(boundary);
    endproperty
    a_slow_edge: assert property (p_slow_edge) else $error("slow indication off boundary");

    property p_sw_set;
        flag_wr && flag_wdata |-> ##2 err_flag_r;
    endproperty
    a_sw_set: assert property (p_sw_set) else $error("software fault not flagged");

    property p_oper_entry;
        (state_r == st_oper) && ($past(state_r) != st_oper) |-> $past(state_r) == st_hold;
    endproperty
    a_oper_entry: assert property (p_oper_entry) else $error("operational without release");

    property p_oper_high;
        !shown_fault_r && !shown_hiz_r && cfg.proto != proto_test && $stable(cfg)
            |=> pins_r.a_oe && (pins_r.a_o || pins_r.b_o);
    endproperty
    a_oper_high: assert property (p_oper_high) else $error("no pin high while operational");

    property p_bistable;
        cfg.proto == proto_bistable && $stable(cfg) && pins_r.a_oe |=> pins_r.a_o != pins_r.b_o;
    endproperty
    a_bistable: assert property (p_bistable) else $error("bistable pins not complementary");

    property p_hold;
        (state_r == st_fault) && flag_wr && !flag_wdata && !fault_any && !func_rst
            |=> (state_r == st_hold) && err_flag_r;
    endproperty
    a_hold: assert property (p_hold) else $error("clear skipped hold");

    property p_src_keep;
        func_rst && src_clr == '0 |=> fault_src_r == ($past(fault_src_r) | $past(fault_q_r));
    endproperty
    a_src_keep: assert property (p_src_keep) else $error("source lost on functional reset");

    c_oper: cover property (state_r == st_oper);
    c_oper_fault: cover property ((state_r == st_oper) ##1 (state_r == st_fault));
    c_slow_fault: cover property (!immediate && shown_fault_r && boundary);
    c_hold_done: cover property ((state_r == st_hold) ##1 (state_r == st_oper));

endmodule : fault_collection_unit

// [verif/fault_supervisor.sv]
// Purpose: behavioural external supervisor watching the two error pins
// Assumes: toggle phase is not tracked, only the shape of the pattern
// Notes: ok is high only for an operational pattern, or in the test protocol whenever both pins are driven and one is high
`timescale 1ns/10ps
module fault_supervisor (
    // configuration known to the supervisor
    input wire fault_pkg::cfg_t cfg,
    // error pins
    input wire fault_pkg::pins_t pins,
    // verdict
    output logic ok
);
    import fault_pkg::*;
    logic a;
    logic b;
    assign a = pins.a_o;
    assign b = pins.b_o;
    always_comb
    begin
        // high z or both pins low counts as failure, never trusted
        ok = pins.a_oe && pins.b_oe && (a || b);
        case (cfg.proto)
            proto_dual_rail: ok = ok && (a != b);
            proto_time_switch: ok = ok && b;
            proto_bistable: ok = ok && (a != b) && (b == cfg.oper_b_high);
            default: ok = ok;
        endcase
    end
endmodule : fault_supervisor

// [verif/fault_collection_unit_test.sv]
// Purpose: self-checking bench for the fault collection unit
// Assumes: half-period counts shortened to 8 and 32 clocks
// Notes: toggle phase is modelled from the fixed divider counts, it has no port of its own
`timescale 1ns/10ps
module fault_collection_unit_test;
    import fault_pkg::*;
    logic clk;
    logic rst;
    logic func_rst;
    logic [7:0] fault_in;
    cfg_t cfg;
    logic flag_wr;
    logic flag_wdata;
    logic [7:0] src_clr;
    logic err_flag_r;
    logic [7:0] fault_src_r;
    pins_t pins_r;
    logic sup_ok;
    int fail_count = 0;
    int checks_done = 0;
    logic [7:0] exp_src;
    localparam int FAST_T = 8;
    localparam int SLOW_T = 32;
    int ph_cnt;
    logic ph_model;
    logic ph_shown;

    fault_collection_unit #(.FAST_HALF(FAST_T), .SLOW_HALF(SLOW_T)) i_fault_collection_unit (.clk(clk), .rst(rst),
        .func_rst(func_rst), .fault_in(fault_in), .cfg(cfg), .flag_wr(flag_wr), .flag_wdata(flag_wdata),
        .src_clr(src_clr), .err_flag_r(err_flag_r), .fault_src_r(fault_src_r), .pins_r(pins_r));
    fault_supervisor i_fault_supervisor (.cfg(cfg), .pins(pins_r), .ok(sup_ok));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // toggle phase from a fixed divider; ph_shown is the phase the pins were last built from
    always @(posedge clk)
    begin
        ph_shown <= ph_model;
        if (rst)
        begin
            ph_cnt <= 0;
            ph_model <= 1'b0;
        end
        else if (ph_cnt >= (cfg.fast_mode ? FAST_T : SLOW_T) - 1)
        begin
            ph_cnt <= 0;
            ph_model <= ~ph_model;
        end
        else
            ph_cnt <= ph_cnt + 1;
    end

    // slow switching may hold a pin change back by up to one half-period
    function automatic int settle(input int base);
        if (!cfg.fast_mode && (cfg.proto == proto_dual_rail || cfg.proto == proto_time_switch))
            return base + SLOW_T;
        return base;
    endfunction : settle

    task automatic summarize;
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // expected pins from the rules; phase comes from the divider model
    function automatic logic [3:0] pat(input logic oper);
        logic a;
        logic b;
        logic bh;
        bh = cfg.oper_b_high;
        a = ph_shown;
        b = oper ? ~a : a;
        if (cfg.proto == proto_time_switch)
            {a, b} = oper ? {ph_shown, 1'b1} : 2'b00;
        if (cfg.proto == proto_bistable)
            {a, b} = oper ? {~bh, bh} : {bh, ~bh};
        if (cfg.proto == proto_test)
            {a, b} = {cfg.test_a, cfg.test_b};
        return {a, 1'b1, b, 1'b1};
    endfunction : pat

    task automatic chk_pins(input logic oper);
        chk({4'h0, pins_r}, {4'h0, pat(oper)});
    endtask : chk_pins

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // bounded wait; running out is a mismatch and ends the run
    task automatic wait_flag(input logic v, input int n);
        for (int k = 0; k < n; k++)
        begin
            tick(1);
            if (err_flag_r === v)
                return;
        end
        fail_count++;
        summarize();
    endtask : wait_flag

    task automatic release_err(input int bound);
        @(posedge clk);
        flag_wr <= 1'b1;
        flag_wdata <= 1'b0;
        @(posedge clk);
        flag_wr <= 1'b0;
        tick(int'(cfg.hold_cycles));
        chk(err_flag_r, 1'b1);
        chk_pins(1'b0);
        wait_flag(1'b0, bound);
        tick(settle(3));
        chk_pins(1'b1);
        chk(sup_ok, 1'b1);
        chk(fault_src_r, exp_src);
    endtask : release_err

    // how: 0 safety mechanism, 1 software write of 1, 2 functional reset
    task automatic raise(input int how, input int bound);
        int i;
        i = $urandom_range(7, 0);
        @(posedge clk);
        fault_in <= (how == 0) ? (8'h01 << i) : 8'h00;
        flag_wr <= (how == 1);
        flag_wdata <= 1'b1;
        func_rst <= (how == 2);
        @(posedge clk);
        fault_in <= 8'h00;
        flag_wr <= 1'b0;
        func_rst <= 1'b0;
        if (how == 0)
            exp_src = exp_src | (8'h01 << i);
        wait_flag(1'b1, bound);
        tick(settle(2));
        chk_pins(1'b0);
        chk(sup_ok, cfg.proto == proto_test);
        tick(20);
        chk(err_flag_r, 1'b1);
        chk(fault_src_r, exp_src);
    endtask : raise

    task automatic clear_src;
        @(posedge clk);
        src_clr <= exp_src;
        @(posedge clk);
        src_clr <= 8'h00;
        exp_src = 8'h00;
        tick(2);
        chk(fault_src_r, exp_src);
    endtask : clear_src

    initial
    begin
        rst = 1'b1;
        func_rst = 1'b0;
        fault_in = 8'h00;
        cfg = '0;
        flag_wr = 1'b0;
        flag_wdata = 1'b0;
        src_clr = 8'h00;
        exp_src = 8'h00;
        void'($urandom(91));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk({4'h0, pins_r}, 8'h00);
        chk(err_flag_r, 1'b1);
        chk(fault_src_r, 8'h00);
        chk(sup_ok, 1'b0);
        for (int p = 0; p < 4; p++)
        begin
            @(posedge clk);
            cfg <= '{proto: proto_t'(p), fast_mode: 1'b1, oper_b_high: 1'($urandom), test_a: 1'b1,
                test_b: 1'($urandom), hold_cycles: 24'($urandom_range(9, 2))};
            release_err(12);
            raise(0, 4);
            release_err(12);
            raise(2, 4);
            release_err(12);
            raise(1, 4);
            clear_src();
        end
        // slow switching waits for the next half-period boundary
        @(posedge clk);
        cfg.fast_mode <= 1'b0;
        cfg.proto <= proto_time_switch;
        release_err(80);
        raise(0, 45);
        summarize();
    end
endmodule : fault_collection_unit_test
